// ===== hw/tlpe_exec.v
// Execution unit for table loads, pointer-step loads, no-op and OR.
// Assumes decoded bytes arrive with their address, a code memory with
// one cycle of read latency and a data RAM read asynchronously.
//
// Contract
// - Table fetch through second pointer pair takes three cycles, loads code byte.
// - Table fetch through extended accumulator takes three cycles, overwrites it.
// - Fetch address is high PC bits plus 8-bit pointer; WX pointer kept.
// - High address bits come from advanced PC, so xxFF uses next page.
// - Code byte upper nibble goes to high, lower to low accumulator.
// - Step-down load copies RAM nibble to A, then decrements low pointer.
// - Step-down skips next instruction when low pointer wraps to all ones.
// - Step-up load copies RAM nibble to A, then increments low pointer.
// - Step-up skips next instruction when low pointer wraps to zero.
// - Step loads keep RAM, carry and high pointer nibble unchanged.
// - No-op is one byte, one cycle, only advances PC.
// - OR immediate is two bytes, two cycles, A gets A OR imm.
// - OR indirect is one byte, one cycle, A gets A OR RAM.
// - OR pair into accumulator: two cycles, EA gets EA OR pair.
// - OR accumulator into pair: two cycles, pair gets pair OR EA.
// - OR writes only destination; source stays unchanged.
// - Pair high register maps to E, low register to A.
`timescale 1ns/1ps
`include "tlpe_consts.vh"

module tlpe_exec #(
    parameter PC_W = 14
) (
    // Clock and reset
    input  wire            clk,
    input  wire            rst_n,
    // Instruction issue
    input  wire            ins_valid,
    input  wire [7:0]      ins_op,
    input  wire [7:0]      ins_arg,
    input  wire [PC_W-1:0] ins_pc,
    output wire            ins_ready,
    // Register preload
    input  wire            wr_en,
    input  wire [3:0]      wr_sel,
    input  wire [3:0]      wr_data,
    // Code memory
    output wire [PC_W-1:0] code_addr,
    output wire            code_rd,
    input  wire [7:0]      code_data,
    // Data RAM
    output wire [7:0]      ram_addr,
    input  wire [3:0]      ram_data,
    // State
    output wire [31:0]     regs,
    output wire            carry,
    output wire            skip_pend,
    // Retire
    output wire            done,
    output wire [PC_W-1:0] done_pc,
    output wire            done_skipped,
    output wire            bad_op
);

// ==========================================================
// Instruction classes
localparam [3:0] C_NOP   = 4'h0;
localparam [3:0] C_TBLWX = 4'h1;
localparam [3:0] C_TBLEA = 4'h2;
localparam [3:0] C_LDDN  = 4'h3;
localparam [3:0] C_LDUP  = 4'h4;
localparam [3:0] C_ORIMM = 4'h5;
localparam [3:0] C_ORIND = 4'h6;
localparam [3:0] C_OREA  = 4'h7;
localparam [3:0] C_ORRR  = 4'h8;
localparam [3:0] C_BAD   = 4'h9;

// ==========================================================
// State
reg  [3:0]      rf_q [0:7];
reg             carry_q;
reg             ready_q;
reg  [1:0]      cnt_q;
reg  [3:0]      cls_q;
reg  [7:0]      arg_q;
reg             cur_skip_q;
reg             skip_q;
reg  [PC_W-1:0] end_pc_q;
reg  [PC_W-1:0] code_addr_q;
reg             code_rd_q;
reg             done_q;
reg  [PC_W-1:0] done_pc_q;
reg             done_skip_q;
reg             bad_q;
integer         i;

// ==========================================================
// Flattened register file view
wire [31:0] rf_flat;
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : g_flat
        assign rf_flat[g*4 +: 4] = rf_q[g];
    end
endgenerate

// ==========================================================
// Decode
reg  [3:0] dec_cls;
reg  [1:0] dec_cyc;
reg  [1:0] dec_len;

always @* begin
    dec_cls = C_BAD;
    dec_cyc = `TLPE_CYC_ONE;
    dec_len = `TLPE_LEN_ONE;
    case (ins_op)
        `TLPE_OP_TBL_WX: begin
            dec_cls = C_TBLWX;
            dec_cyc = `TLPE_CYC_TBL;
        end
        `TLPE_OP_TBL_EA: begin
            dec_cls = C_TBLEA;
            dec_cyc = `TLPE_CYC_TBL;
        end
        `TLPE_OP_LD_DN: begin
            dec_cls = C_LDDN;
            dec_cyc = `TLPE_CYC_STEP;
        end
        `TLPE_OP_LD_UP: begin
            dec_cls = C_LDUP;
            dec_cyc = `TLPE_CYC_STEP;
        end
        `TLPE_OP_NOP: begin
            dec_cls = C_NOP;
        end
        `TLPE_OP_OR_IND: begin
            dec_cls = C_ORIND;
        end
        `TLPE_OP_OR_IMM: begin
            dec_len = `TLPE_LEN_TWO;
            dec_cyc = `TLPE_CYC_TWO;
            if (ins_arg[7:4] == `TLPE_ARG_IMM_HI) begin
                dec_cls = C_ORIMM;
            end
        end
        `TLPE_OP_OR_PAIR: begin
            dec_len = `TLPE_LEN_TWO;
            dec_cyc = `TLPE_CYC_TWO;
            if (ins_arg[0] == 1'b0) begin
                if (ins_arg[7:3] == `TLPE_ARG_TO_EA) begin
                    dec_cls = C_OREA;
                end else if (ins_arg[7:3] == `TLPE_ARG_TO_RR) begin
                    dec_cls = C_ORRR;
                end
            end
        end
        default: begin
            dec_cls = C_BAD;
        end
    endcase
end

// ==========================================================
// Operand paths
wire            take;
wire            wr_ok;
wire [PC_W-1:0] pc_adv;
wire [PC_W-1:0] len_ext;
wire [7:0]      tbl_ptr;
wire [7:0]      ea_val;
wire [7:0]      pair_val;
wire [3:0]      step_res;
wire            step_wrap;
wire            last;

assign take    = ins_valid & ready_q;
assign wr_ok   = wr_en & ready_q & ~ins_valid;
assign len_ext = {{(PC_W-2){1'b0}}, dec_len};
assign pc_adv  = ins_pc + {{(PC_W-1){1'b0}}, 1'b1};
assign ea_val  = {rf_q[`TLPE_IX_E], rf_q[`TLPE_IX_A]};
assign tbl_ptr = (dec_cls == C_TBLWX) ?
                 {rf_q[`TLPE_IX_W], rf_q[`TLPE_IX_X]} : ea_val;
assign last    = ~ready_q & (cnt_q == 2'h1);

tlpe_pair_pick u_pick (
    .rf_flat (rf_flat),
    .sel     (arg_q[2:1]),
    .pair    (pair_val)
);

tlpe_nibble_step #(
    .W (4)
) u_step (
    .val  (rf_q[`TLPE_IX_L]),
    .down (cls_q == C_LDDN),
    .res  (step_res),
    .wrap (step_wrap)
);

// ==========================================================
// Sequencer and register file
always @(posedge clk) begin
    if (!rst_n) begin
        for (i = 0; i < 8; i = i + 1) begin
            rf_q[i] <= `TLPE_RST_NIB;
        end
        ready_q     <= 1'b1;
        cnt_q       <= 2'h0;
        cls_q       <= C_NOP;
        arg_q       <= 8'h00;
        cur_skip_q  <= 1'b0;
        skip_q      <= 1'b0;
        end_pc_q    <= {PC_W{1'b0}};
    end else begin
        if (wr_ok & ~wr_sel[3]) begin
            rf_q[wr_sel[2:0]] <= wr_data;
        end
        if (take) begin
            cls_q      <= dec_cls;
            arg_q      <= ins_arg;
            cur_skip_q <= skip_q;
            skip_q     <= 1'b0;
            end_pc_q   <= ins_pc + len_ext;
            cnt_q      <= dec_cyc - 2'h1;
            ready_q    <= (dec_cyc == `TLPE_CYC_ONE);
            case (dec_cls)
                C_LDDN, C_LDUP: begin
                    if (!skip_q) begin
                        rf_q[`TLPE_IX_A] <= ram_data;
                    end
                end
                C_ORIND: begin
                    if (!skip_q) begin
                        rf_q[`TLPE_IX_A] <= rf_q[`TLPE_IX_A] | ram_data;
                    end
                end
                default: begin
                    cls_q <= dec_cls;
                end
            endcase
        end else if (!ready_q) begin
            cnt_q <= cnt_q - 2'h1;
            if (last) begin
                ready_q     <= 1'b1;
                if (!cur_skip_q) begin
                    case (cls_q)
                        C_TBLWX, C_TBLEA: begin
                            rf_q[`TLPE_IX_E] <= code_data[7:4];
                            rf_q[`TLPE_IX_A] <= code_data[3:0];
                        end
                        C_LDDN, C_LDUP: begin
                            rf_q[`TLPE_IX_L] <= step_res;
                            skip_q           <= step_wrap;
                        end
                        C_ORIMM: begin
                            rf_q[`TLPE_IX_A] <= rf_q[`TLPE_IX_A] | arg_q[3:0];
                        end
                        C_OREA: begin
                            rf_q[`TLPE_IX_E] <= ea_val[7:4] | pair_val[7:4];
                            rf_q[`TLPE_IX_A] <= ea_val[3:0] | pair_val[3:0];
                        end
                        C_ORRR: begin
                            rf_q[{arg_q[2:1], 1'b1}] <= pair_val[7:4] | ea_val[7:4];
                            rf_q[{arg_q[2:1], 1'b0}] <= pair_val[3:0] | ea_val[3:0];
                        end
                        default: begin
                            cnt_q <= 2'h0;
                        end
                    endcase
                end
            end
        end
    end
end

// ==========================================================
// Carry flag, written only by preload
always @(posedge clk) begin
    if (!rst_n) begin
        carry_q <= `TLPE_RST_CARRY;
    end else if (wr_ok & wr_sel[3]) begin
        carry_q <= wr_data[0];
    end
end

// ==========================================================
// Code memory request
wire tbl_take;

assign tbl_take = take & ((dec_cls == C_TBLWX) | (dec_cls == C_TBLEA));

always @(posedge clk) begin
    if (!rst_n) begin
        code_addr_q <= {PC_W{1'b0}};
        code_rd_q   <= 1'b0;
    end else begin
        code_rd_q <= 1'b0;
        if (tbl_take) begin
            code_addr_q <= {pc_adv[PC_W-1:8], tbl_ptr};
            code_rd_q   <= ~skip_q;
        end
    end
end

// ==========================================================
// Retire report
wire fin_now;

assign fin_now = take & (dec_cyc == `TLPE_CYC_ONE);

always @(posedge clk) begin
    if (!rst_n) begin
        done_q      <= 1'b0;
        done_pc_q   <= {PC_W{1'b0}};
        done_skip_q <= 1'b0;
        bad_q       <= 1'b0;
    end else begin
        done_q <= fin_now | last;
        bad_q  <= 1'b0;
        if (fin_now) begin
            done_pc_q   <= ins_pc + len_ext;
            done_skip_q <= skip_q;
            bad_q       <= (dec_cls == C_BAD);
        end else if (last) begin
            done_pc_q   <= end_pc_q;
            done_skip_q <= cur_skip_q;
            bad_q       <= (cls_q == C_BAD);
        end
    end
end

// ==========================================================
// Outputs
assign ins_ready    = ready_q;
assign code_addr    = code_addr_q;
assign code_rd      = code_rd_q;
assign ram_addr     = {rf_q[`TLPE_IX_H], rf_q[`TLPE_IX_L]};
assign regs         = rf_flat;
assign carry        = carry_q;
assign skip_pend    = skip_q;
assign done         = done_q;
assign done_pc      = done_pc_q;
assign done_skipped = done_skip_q;
assign bad_op       = bad_q;

endmodule // tlpe_exec

// ===== hw/tlpe_consts.vh
// Constants for the table-load, pointer-step and OR execution unit.
// Assumes inclusion by the execution unit, its checker and its bench.
`ifndef TLPE_CONSTS_VH
`define TLPE_CONSTS_VH

// ==========================================================
// Opcodes, first byte
`define TLPE_OP_TBL_WX   8'hcc
`define TLPE_OP_TBL_EA   8'hc8
`define TLPE_OP_LD_DN    8'h8b
`define TLPE_OP_LD_UP    8'h8a
`define TLPE_OP_NOP      8'ha0
`define TLPE_OP_OR_IMM   8'hdd
`define TLPE_OP_OR_IND   8'h3a
`define TLPE_OP_OR_PAIR  8'hdc

// ==========================================================
// Second byte patterns
`define TLPE_ARG_IMM_HI  4'h2
`define TLPE_ARG_TO_EA   5'h05
`define TLPE_ARG_TO_RR   5'h04

// ==========================================================
// Instruction lengths in bytes
`define TLPE_LEN_ONE     2'h1
`define TLPE_LEN_TWO     2'h2

// ==========================================================
// Cycle counts
`define TLPE_CYC_TBL     2'h3
`define TLPE_CYC_STEP    2'h2
`define TLPE_CYC_ONE     2'h1
`define TLPE_CYC_TWO     2'h2

// ==========================================================
// Register file indices
`define TLPE_IX_A        3'h0
`define TLPE_IX_E        3'h1
`define TLPE_IX_L        3'h2
`define TLPE_IX_H        3'h3
`define TLPE_IX_X        3'h4
`define TLPE_IX_W        3'h5

// ==========================================================
// Reset values
`define TLPE_RST_NIB     4'h0
`define TLPE_RST_CARRY   1'b0

`endif

// ===== hw/tlpe_nibble_step.v
// Steps a pointer nibble up or down by one and flags the wrap.
// Assumes a purely combinational use inside the execution unit.
`timescale 1ns/1ps

module tlpe_nibble_step #(
    parameter W = 4
) (
    // Operand
    input  wire [W-1:0] val,
    input  wire         down,
    // Result
    output wire [W-1:0] res,
    output wire         wrap
);

// ==========================================================
// Step and wrap detect
wire [W-1:0] one_w;
assign one_w = {{(W-1){1'b0}}, 1'b1};
assign res   = down ? (val - one_w) : (val + one_w);
assign wrap  = down ? (res == {W{1'b1}}) : (res == {W{1'b0}});

endmodule // tlpe_nibble_step

// ===== hw/tlpe_pair_pick.v
// Selects one byte pair out of the flattened register file.
// Assumes pair p holds its low nibble at entry 2p, high at 2p+1.
`timescale 1ns/1ps

module tlpe_pair_pick (
    // Register file
    input  wire [31:0] rf_flat,
    // Pair select
    input  wire [1:0]  sel,
    // Byte out
    output wire [7:0]  pair
);

// ==========================================================
// Pair mux, high nibble from the odd entry
assign pair = rf_flat[{sel, 3'b000} +: 8];

endmodule // tlpe_pair_pick

// ===== verif/tlpe_exec_props.sv
// Checker for the table-load, pointer-step and OR execution unit.
// Assumes a bind onto tlpe_exec; sees only its ports.
`timescale 1ns/1ps
`include "tlpe_consts.vh"

module tlpe_exec_props #(
    parameter PC_W = 14
) (
    // Clock and reset
    input wire            clk,
    input wire            rst_n,
    // Instruction issue
    input wire            ins_valid,
    input wire [7:0]      ins_op,
    input wire [PC_W-1:0] ins_pc,
    input wire            ins_ready,
    // Register preload
    input wire            wr_en,
    input wire [3:0]      wr_sel,
    // Memories
    input wire [PC_W-1:0] code_addr,
    input wire            code_rd,
    input wire [7:0]      code_data,
    input wire [3:0]      ram_data,
    // State and retire
    input wire [31:0]     regs,
    input wire            carry,
    input wire            skip_pend,
    input wire            done
);
    // ==========================================================
    // Helpers
    wire            tk  = ins_valid && ins_ready;
    wire            run = tk && !skip_pend;
    wire            tbl = ins_op == `TLPE_OP_TBL_WX || ins_op == `TLPE_OP_TBL_EA;
    wire            stp = ins_op == `TLPE_OP_LD_DN || ins_op == `TLPE_OP_LD_UP;
    wire [3:0]      lo  = regs[11:8];
    wire [3:0]      hi  = regs[15:12];
    wire [PC_W-1:0] pc1 = ins_pc + 1'b1;
    reg  [PC_W-1:0] addr_q;

    always @(posedge clk)
        addr_q <= {pc1[PC_W-1:8], ins_op[2] ? regs[23:16] : regs[7:0]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence busy_two;
        (!done && !ins_ready) [*2];
    endsequence
    sequence step_end;
        !done ##1 done;
    endsequence

    // ==========================================================
    // Properties
    tbl_time_a: assert property (
        tk && tbl |=> busy_two ##1 done && ins_ready) else $error("table fetch timing");
    tbl_addr_a: assert property (
        run && tbl |=> code_rd && code_addr == addr_q) else $error("table address");
    tbl_route_a: assert property (
        run && tbl |=> ##2 regs[7:0] == $past(code_data)) else $error("code byte routing");
    step_down_a: assert property (
        run && ins_op == `TLPE_OP_LD_DN |=> step_end ##0 lo == $past(lo, 2) - 4'h1
        && skip_pend == (lo == 4'hf)) else $error("step down");
    step_up_a: assert property (
        run && ins_op == `TLPE_OP_LD_UP |=> step_end ##0 lo == $past(lo, 2) + 4'h1
        && skip_pend == (lo == 4'h0)) else $error("step up");
    step_load_a: assert property (
        run && stp |=> regs[3:0] == $past(ram_data) && hi == $past(hi))
        else $error("step load value");
    carry_hold_a: assert property (
        rst_n && !(wr_en && wr_sel[3] && ins_ready && !ins_valid) |=> $stable(carry))
        else $error("carry changed");
    or_ind_a: assert property (
        run && ins_op == `TLPE_OP_OR_IND |=> done && regs == ($past(regs) | {28'h0,
        $past(ram_data)})) else $error("or indirect");
    skip_quiet_a: assert property (
        tk && skip_pend |=> !skip_pend && !code_rd && regs == $past(regs))
        else $error("skipped instruction acted");
    nop_only_a: assert property (
        run && ins_op == `TLPE_OP_NOP |=> done && ins_ready && regs == $past(regs))
        else $error("no-op acted");
endmodule // tlpe_exec_props

// ===== verif/tlpe_mem_model.sv
// Program memory with one cycle of read latency and an async data RAM.
// Assumes a 14-bit code address; data outside the read slot is garbage.
`timescale 1ns/1ps

module tlpe_mem_model (
    // Clock
    input  wire         clk,
    // Code memory
    input  wire [13:0]  code_addr,
    input  wire         code_rd,
    output logic [7:0]  code_data = 8'h5a,
    // Data RAM
    input  wire [7:0]   ram_addr,
    output wire [3:0]   ram_data
);
    // ==========================================================
    // Contents follow the address; code bus toggles when not read
    always @(posedge clk)
        code_data <= code_rd ? code_addr[7:0] ^ {code_addr[13:8], 2'b10} : ~code_data;

    assign ram_data = ram_addr[7:4] ^ ~ram_addr[3:0];
endmodule // tlpe_mem_model

// ===== verif/tlpe_exec_tb.sv
// Self-checking bench for the table-load, pointer-step and OR unit.
// Assumes the memory model and the checker are compiled first.
`timescale 1ns/1ps
`include "tlpe_consts.vh"

module tlpe_exec_tb;
    logic        clk, rst_n, ins_valid, wr_en, m_skip, m_carry;
    logic [7:0]  ins_op, ins_arg, r_op, r_arg;
    logic [13:0] ins_pc, r_pc;
    logic [3:0]  wr_sel, wr_data;
    logic [3:0]  m [8];
    logic [7:0]  ops [8];
    wire         ins_ready, code_rd, carry, skip_pend, done, done_skipped, bad_op;
    wire  [13:0] code_addr, done_pc;
    wire  [7:0]  code_data, ram_addr;
    wire  [3:0]  ram_data;
    wire  [31:0] regs;
    int          n_errors, comparisons, cycles, tick, seed;

    tlpe_exec dut (.clk, .rst_n, .ins_valid, .ins_op, .ins_arg, .ins_pc, .ins_ready, .wr_en,
        .wr_sel, .wr_data, .code_addr, .code_rd, .code_data, .ram_addr, .ram_data, .regs,
        .carry, .skip_pend, .done, .done_pc, .done_skipped, .bad_op);
    tlpe_mem_model mem (.clk, .code_addr, .code_rd, .code_data, .ram_addr, .ram_data);

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        tick++;
        if (tick == 5000) begin
            n_errors++;
            summarize();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [3:0] rn(input logic [7:0] x);
        return x[7:4] ^ ~x[3:0];
    endfunction

    task automatic chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic pl(input logic [3:0] s, d);
        ins_valid = 0;
        wr_en = 1;
        wr_sel = s;
        wr_data = d;
        @(negedge clk);
        wr_en = 0;
        if (s[3]) m_carry = d[0];
        else m[s[2:0]] = d;
        @(negedge clk);
    endtask

    task automatic issue(input logic [7:0] op, arg, input logic [13:0] pc);
        logic [13:0] a;
        logic [7:0]  b;
        logic        sk, nsk, bad;
        int          lo, cyc, len;
        ins_valid = 1;
        ins_op = op;
        ins_arg = arg;
        ins_pc = pc;
        sk = m_skip;
        nsk = 0;
        bad = 0;
        cyc = 1;
        len = (op == `TLPE_OP_OR_IMM || op == `TLPE_OP_OR_PAIR) ? 2 : 1;
        lo = 2 * arg[2:1];
        a = pc + 14'h1;
        a = {a[13:8], op[2] ? {m[5], m[4]} : {m[1], m[0]}};
        b = a[7:0] ^ {a[13:8], 2'b10};
        case (op)
            `TLPE_OP_TBL_WX, `TLPE_OP_TBL_EA: begin
                cyc = 3;
                if (!sk) {m[1], m[0]} = b;
            end
            `TLPE_OP_LD_DN, `TLPE_OP_LD_UP: begin
                cyc = 2;
                if (!sk) begin
                    m[0] = rn({m[3], m[2]});
                    m[2] = op[0] ? m[2] - 4'h1 : m[2] + 4'h1;
                    nsk = m[2] == (op[0] ? 4'hf : 4'h0);
                end
            end
            `TLPE_OP_OR_IMM: begin
                cyc = 2;
                bad = arg[7:4] != 4'h2;
                if (!sk && !bad) m[0] |= arg[3:0];
            end
            `TLPE_OP_OR_IND: if (!sk) m[0] |= rn({m[3], m[2]});
            `TLPE_OP_OR_PAIR: begin
                cyc = 2;
                bad = arg[7:4] != 4'h2 || arg[0];
                if (bad) lo = 0;
                if (!sk && arg[3]) {m[1], m[0]} = {m[1], m[0]} | {m[lo + 1], m[lo]};
                if (!sk && !arg[3]) {m[lo + 1], m[lo]} = {m[lo + 1], m[lo]} | {m[1], m[0]};
            end
            `TLPE_OP_NOP: ;
            default: bad = 1;
        endcase
        m_skip = nsk;
        cycles = 0;
        do begin
            @(negedge clk);
            cycles++;
        end while (done !== 1'b1 && cycles < 8);
        chk(cycles, cyc);
        chk(regs, {m[7], m[6], m[5], m[4], m[3], m[2], m[1], m[0]});
        chk(done_pc, 14'(pc + len));
        chk({done_skipped, skip_pend, carry, bad_op}, {sk, m_skip, m_carry, bad});
    endtask

    task automatic summarize;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'hab1e0a3e;
        {rst_n, ins_valid, wr_en, ins_op, ins_arg, ins_pc, wr_sel, wr_data} = '0;
        {m_skip, m_carry} = '0;
        foreach (m[i]) m[i] = 4'h0;
        ops = '{`TLPE_OP_TBL_WX, `TLPE_OP_TBL_EA, `TLPE_OP_LD_DN, `TLPE_OP_LD_UP,
                `TLPE_OP_NOP, `TLPE_OP_OR_IMM, `TLPE_OP_OR_IND, `TLPE_OP_OR_PAIR};
        repeat (2) @(negedge clk);
        rst_n = 1;
        chk(regs, 32'h0);
        chk({ins_ready, skip_pend, carry, done}, 4'h8);
        for (int i = 0; i < 16; i++) pl(i[3:0], 4'($random(seed)));
        pl(4'h2, 4'h0);
        issue(`TLPE_OP_LD_DN, 8'h00, 14'h0100);
        issue(`TLPE_OP_OR_IMM, 8'h2f, 14'h0101);
        pl(4'h2, 4'hf);
        issue(`TLPE_OP_LD_UP, 8'h00, 14'h0102);
        issue(`TLPE_OP_TBL_WX, 8'h00, 14'h0103);
        issue(`TLPE_OP_TBL_EA, 8'h00, 14'h01ff);
        repeat (3) issue(`TLPE_OP_NOP, 8'h00, 14'h0200);
        issue(8'hff, 8'h00, 14'h0203);
        issue(`TLPE_OP_OR_IMM, 8'h7f, 14'h0204);
        issue(`TLPE_OP_OR_PAIR, 8'h2b, 14'h0206);
        for (int k = 0; k < 8; k++) issue(`TLPE_OP_OR_PAIR, {4'h2, k[2:0], 1'b0}, 14'h0300);
        for (int i = 0; i < 300; i++) begin
            r_op = ops[3'($random(seed))];
            r_arg = $random(seed);
            if (r_op == `TLPE_OP_OR_PAIR) r_arg = {4'h2, r_arg[3:1], 1'b0};
            if (r_op == `TLPE_OP_OR_IMM) r_arg = {4'h2, r_arg[3:0]};
            r_pc = $random(seed);
            if (i % 4 == 0) r_pc[7:0] = 8'hff;
            if (i % 8 == 0) pl(4'($random(seed)), 4'($random(seed)));
            issue(r_op, r_arg, r_pc);
        end
        ins_valid = 0;
        repeat (2) @(negedge clk);
        summarize();
    end
endmodule // tlpe_exec_tb

bind tlpe_exec tlpe_exec_props #(.PC_W(PC_W)) props (.clk, .rst_n, .ins_valid, .ins_op,
    .ins_pc, .ins_ready, .wr_en, .wr_sel, .code_addr, .code_rd, .code_data, .ram_data,
    .regs, .carry, .skip_pend, .done);
